// ===== design/sequencer_pkg.sv
// Purpose: Shared constants and carriers of the microprogram next-address sequencer.
// Assumes: One 100 MHz clock; T1 and T3 machine phases arrive as one-cycle enables.
// Notes: Register offsets are byte addresses on the AXI4-Lite slave.
package sequencer_pkg;

    localparam int ADDR_W = 8;
    localparam int SEL_W = 4;
    localparam int INSTR_W = 16;

    localparam logic [ADDR_W-1:0] RESTART_ADDRESS = 8'h80;
    localparam logic [SEL_W-1:0] CODE_NONE = 4'h0;
    localparam logic [SEL_W-1:0] CODE_FIVE = 4'h5;
    localparam logic [SEL_W-1:0] CODE_FOURTEEN = 4'hc;
    localparam logic [SEL_W-1:0] CODE_FIFTEEN = 4'hd;

    localparam int BRANCH_HI_BIT = 5;
    localparam int BRANCH_LO_BIT = 4;
    localparam int SRC_MODE_LSB = 9;
    localparam int DUP_BIT_LO = 9;
    localparam int DUP_BIT_HI = 10;

    localparam logic [ADDR_W-1:0] CONSOLE_MASK = 8'hc7;

    localparam logic [11:0] REG_CONTROL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_INSTR = 12'h008;
    localparam int CTRL_RESTART_BIT = 0;
    localparam int CTRL_HOLD_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [ADDR_W-1:0] next_address_field;
        logic [SEL_W-1:0] branch_select_field;
        logic decode_fork_enable;
        logic operand_fork_enable;
        logic execute_fork_enable;
        logic instr_reg_load_bit;
    } microword_t;

    typedef struct packed {
        logic [ADDR_W-1:0] decode_fork_addr;
        logic [ADDR_W-1:0] operand_fork_addr;
        logic [ADDR_W-1:0] execute_fork_addr;
    } fork_addr_t;

    typedef struct packed {
        logic [15:0] cond_hi;
        logic [15:0] cond_lo;
        logic odd_byte_destination;
        logic divide_terminate;
        logic flow_jump_class;
        logic no_write_class;
    } branch_cond_t;

    typedef enum logic [2:0] {
        FORK_NONE = 3'b001,
        FORK_SUPPRESSED = 3'b010,
        FORK_TAKEN = 3'b100
    } fork_state_t;

endpackage

// ===== design/microprogram_next_address_sequencer.sv
// Purpose: Next-address selection, microaddress register and instruction registers.
// Assumes: Phase enables, microword, conditions and fork addresses are same-clock logic.
// Notes: Fork addresses arrive as bit-clear masks; fork decode tables live outside.
`timescale 1ns/10ps
module microprogram_next_address_sequencer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic phase_t1,
    input wire logic phase_t3,
    input wire logic force_restart_address,
    input wire logic decode_state,
    input wire sequencer_pkg::microword_t microword,
    input wire sequencer_pkg::fork_addr_t fork_addr,
    input wire sequencer_pkg::branch_cond_t branch_cond,
    input wire logic [sequencer_pkg::ADDR_W-1:0] console_branch,
    input wire logic [sequencer_pkg::INSTR_W-1:0] instr_word,
    output logic [sequencer_pkg::ADDR_W-1:0] microaddress_register,
    output logic [sequencer_pkg::INSTR_W-1:0] main_instr,
    output logic [sequencer_pkg::INSTR_W+1:0] fast_decode_instr_copy,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // Other codes use all four select bits to index both vectors, high bit from cond_hi and low from cond_lo; codes 5 and 15 read named conditions, 00 and 14 ground.
    function automatic logic [1:0] branch_bits(input logic [3:0] sel,
                                               input sequencer_pkg::branch_cond_t c);
        logic [1:0] r;
        r = 2'b00;
        case (sel)
            sequencer_pkg::CODE_NONE,
            sequencer_pkg::CODE_FOURTEEN: begin
                r = 2'b00;
            end
            sequencer_pkg::CODE_FIVE: begin
                r = {c.odd_byte_destination, c.divide_terminate};
            end
            sequencer_pkg::CODE_FIFTEEN: begin
                r = {c.flow_jump_class, c.no_write_class};
            end
            default: begin
                r = {c.cond_hi[{sel[3], sel[2], sel[1:0]}],
                     c.cond_lo[{sel[3], sel[2], sel[1:0]}]};
            end
        endcase
        return r;
    endfunction

    logic [sequencer_pkg::ADDR_W-1:0] next_microaddress_input;
    logic [1:0] branch_now;
    logic source_mode_deferred;
    logic branch_code_fourteen;
    logic branch_code_fifteen;
    logic branch_code_five;
    logic decode_go;
    logic operand_go;
    logic execute_go;
    logic [sequencer_pkg::ADDR_W-1:0] field_or_branch;
    logic [sequencer_pkg::ADDR_W-1:0] fork_mask;
    logic ctrl_hold;
    logic soft_restart;
    logic restart_pending;
    sequencer_pkg::fork_state_t fork_state;
    logic [1:0] last_branch;

    assign branch_code_fourteen = microword.branch_select_field == sequencer_pkg::CODE_FOURTEEN;
    assign branch_code_fifteen = microword.branch_select_field == sequencer_pkg::CODE_FIFTEEN;
    assign branch_code_five = microword.branch_select_field == sequencer_pkg::CODE_FIVE;

    // Source modes 3, 5 and 7 are the odd modes other than 1.
    assign source_mode_deferred = main_instr[sequencer_pkg::SRC_MODE_LSB] &
        (main_instr[sequencer_pkg::SRC_MODE_LSB+1] | main_instr[sequencer_pkg::SRC_MODE_LSB+2]);

    // Conditions are read straight from the inputs so the address settles before T3.
    assign branch_now = branch_bits(microword.branch_select_field, branch_cond);

    always_comb begin
        decode_go = microword.decode_fork_enable;
        operand_go = microword.operand_fork_enable &
            !(branch_code_fourteen & source_mode_deferred);
        execute_go = microword.execute_fork_enable &
            !(branch_code_fifteen & !branch_cond.flow_jump_class) &
            !(branch_code_five & branch_cond.odd_byte_destination);
    end

    always_comb begin
        field_or_branch = microword.next_address_field;
        field_or_branch[sequencer_pkg::BRANCH_HI_BIT] =
            microword.next_address_field[sequencer_pkg::BRANCH_HI_BIT] | branch_now[1];
        field_or_branch[sequencer_pkg::BRANCH_LO_BIT] =
            microword.next_address_field[sequencer_pkg::BRANCH_LO_BIT] | branch_now[0];
        if (branch_code_fourteen) begin
            field_or_branch = field_or_branch | (console_branch & sequencer_pkg::CONSOLE_MASK);
        end
    end

    // A fork clears bits; with the field at all ones its own address comes through.
    always_comb begin
        fork_mask = '1;
        if (decode_go) begin
            fork_mask = fork_addr.decode_fork_addr;
        end else if (operand_go) begin
            fork_mask = fork_addr.operand_fork_addr;
        end else if (execute_go) begin
            fork_mask = fork_addr.execute_fork_addr;
        end
        next_microaddress_input = field_or_branch & fork_mask;
    end

    // A restart asked for between T3 edges is held so it cannot be missed.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            restart_pending <= 1'b0;
        end else if (phase_t3) begin
            restart_pending <= 1'b0;
        end else if (soft_restart) begin
            restart_pending <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            microaddress_register <= sequencer_pkg::RESTART_ADDRESS;
        end else if (force_restart_address || (phase_t3 && (restart_pending || soft_restart))) begin
            microaddress_register <= sequencer_pkg::RESTART_ADDRESS;
        end else if (phase_t3 && !ctrl_hold) begin
            microaddress_register <= next_microaddress_input;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fork_state <= sequencer_pkg::FORK_NONE;
            last_branch <= 2'b00;
        end else if (phase_t3) begin
            last_branch <= branch_now;
            if (decode_go || operand_go || execute_go) begin
                fork_state <= sequencer_pkg::FORK_TAKEN;
            end else if (microword.operand_fork_enable || microword.execute_fork_enable) begin
                fork_state <= sequencer_pkg::FORK_SUPPRESSED;
            end else begin
                fork_state <= sequencer_pkg::FORK_NONE;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_instr <= '0;
            fast_decode_instr_copy <= '0;
        end else if (phase_t1 && decode_state && microword.instr_reg_load_bit) begin
            main_instr <= instr_word;
            fast_decode_instr_copy <= {instr_word[sequencer_pkg::DUP_BIT_HI],
                instr_word[sequencer_pkg::DUP_BIT_LO], instr_word};
        end
    end

    // AXI4-Lite slave: address and data are taken in either order, one write at a time.
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (aw_held && w_held) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (aw_held && w_held) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sequencer_pkg::RESP_OKAY;
        end else if (aw_held && w_held) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[11:2] == sequencer_pkg::REG_CONTROL[11:2]) ?
                sequencer_pkg::RESP_OKAY : sequencer_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Restart is a write-one pulse; hold stops normal T3 loads for single stepping, but restarts still load the address.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_hold <= 1'b0;
            soft_restart <= 1'b0;
        end else begin
            soft_restart <= 1'b0;
            if (aw_held && w_held && w_strb[0] &&
                aw_addr[11:2] == sequencer_pkg::REG_CONTROL[11:2]) begin
                ctrl_hold <= w_data[sequencer_pkg::CTRL_HOLD_BIT];
                soft_restart <= w_data[sequencer_pkg::CTRL_RESTART_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= sequencer_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= sequencer_pkg::RESP_OKAY;
            case (s_axi_araddr[11:2])
                sequencer_pkg::REG_CONTROL[11:2]: begin
                    s_axi_rdata <= {30'h0, ctrl_hold, 1'b0};
                end
                sequencer_pkg::REG_STATUS[11:2]: begin
                    s_axi_rdata <= {19'h0, fork_state, last_branch, microaddress_register};
                end
                sequencer_pkg::REG_INSTR[11:2]: begin
                    s_axi_rdata <= {fast_decode_instr_copy[17:16], 14'h0, main_instr};
                end
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= sequencer_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    sequence s_t3_restart;
        phase_t3 && force_restart_address;
    endsequence

    sequence s_ir_load;
        phase_t1 && decode_state && microword.instr_reg_load_bit;
    endsequence

    a_restart_address_forced: assert property (@(posedge aclk) disable iff (!aresetn)
        s_t3_restart |=> microaddress_register == sequencer_pkg::RESTART_ADDRESS)
        else $error("Restart did not force address 200 octal.");

    a_plain_next_address: assert property (@(posedge aclk) disable iff (!aresetn)
        (phase_t3 && !force_restart_address && !ctrl_hold && !soft_restart && !restart_pending &&
         !microword.decode_fork_enable && !microword.operand_fork_enable &&
         !microword.execute_fork_enable && microword.branch_select_field == 4'h0)
        |=> microaddress_register == $past(microword.next_address_field))
        else $error("Next address differs from the next-address field.");

    a_decode_fork_used: assert property (@(posedge aclk) disable iff (!aresetn)
        microword.decode_fork_enable |->
            next_microaddress_input == (field_or_branch & fork_addr.decode_fork_addr))
        else $error("Decode fork address not applied.");

    a_operand_fork_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        (branch_code_fourteen && source_mode_deferred) |-> !operand_go)
        else $error("Operand fork not suppressed for deferred source mode.");

    a_execute_fork_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        (branch_code_five && microword.execute_fork_enable) |->
            execute_go == !branch_cond.odd_byte_destination)
        else $error("Execute fork gating wrong under code five.");

    a_branch_bits_only: assert property (@(posedge aclk) disable iff (!aresetn)
        (!decode_go && !operand_go && !execute_go && !branch_code_fourteen) |->
            (next_microaddress_input & 8'hcf) == (microword.next_address_field & 8'hcf))
        else $error("Branch altered a bit other than 5 or 4.");

    a_quiet_codes: assert property (@(posedge aclk) disable iff (!aresetn)
        (microword.branch_select_field == 4'h0 || branch_code_fourteen) |-> branch_now == 2'b00)
        else $error("Codes 00 or 14 produced a branch.");

    a_ir_loads_t1: assert property (@(posedge aclk) disable iff (!aresetn)
        s_ir_load |=> main_instr == $past(instr_word) &&
            fast_decode_instr_copy[15:0] == $past(instr_word))
        else $error("Instruction registers missed the T1 load.");

    a_ir_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        !s_ir_load |=> $stable(main_instr))
        else $error("Main instruction register changed outside T1 load.");

    a_addr_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        (!phase_t3 && !force_restart_address) |=> $stable(microaddress_register))
        else $error("Microaddress changed outside T3.");

    a_flow_jump_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        (branch_code_fifteen && microword.execute_fork_enable) |->
            execute_go == branch_cond.flow_jump_class)
        else $error("Execute fork gating wrong under code fifteen.");

    a_code_five_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        branch_code_five |->
            branch_now == {branch_cond.odd_byte_destination, branch_cond.divide_terminate})
        else $error("Code five branch sources wrong.");

    a_code_fifteen_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        branch_code_fifteen |->
            branch_now == {branch_cond.flow_jump_class, branch_cond.no_write_class})
        else $error("Code fifteen branch sources wrong.");

    a_fast_dup_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        fast_decode_instr_copy[17:16] == fast_decode_instr_copy[10:9])
        else $error("Fast copy duplicated bits disagree.");

endmodule // microprogram_next_address_sequencer

// ===== tb/rom_status_model.sv
// Purpose: Far-side model holding the microprogram ROM and making the T1 and T3 phases.
// Assumes: One machine cycle is four clocks; T1 in the first clock and T3 in the third.
// Notes: The ROM is filled by the bench before reset is released.
`timescale 1ns/10ps
module rom_status_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic [sequencer_pkg::ADDR_W-1:0] rom_address,
    output sequencer_pkg::microword_t microword,
    output logic phase_t1,
    output logic phase_t3
);
    sequencer_pkg::microword_t rom [0:255];
    logic [1:0] phase_count;

    // Phases stop while run is low, so register writes never race a microaddress load.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_count <= 2'd0;
        end else if (run) begin
            phase_count <= phase_count + 2'd1;
        end
    end

    assign phase_t1 = run & (phase_count == 2'd0);
    assign phase_t3 = run & (phase_count == 2'd2);
    assign microword = rom[rom_address];
endmodule // rom_status_model

// ===== tb/test_microprogram_next_address_sequencer.sv
// Purpose: Self-checking bench for the next-address sequencer against a behavioural model.
// Assumes: Conditions, fork masks and instruction words are random each clock.
// Notes: Control writes are made with the phases stopped, so the model updates exactly.
`timescale 1ns/10ps
module test_microprogram_next_address_sequencer;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic run = 1'b0;
    logic phase_t1, phase_t3;
    logic force_restart_address = 1'b0;
    logic decode_state = 1'b0;
    sequencer_pkg::microword_t microword, w;
    sequencer_pkg::fork_addr_t fork_addr = '0;
    sequencer_pkg::branch_cond_t branch_cond = '0;
    logic [7:0] console_branch = 8'h00;
    logic [15:0] instr_word = 16'h0000;
    logic [7:0] microaddress_register;
    logic [15:0] main_instr;
    logic [17:0] fast_decode_instr_copy;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    integer seed = 32'h77680fb2;
    int failures = 0;
    int checked = 0;
    logic cmp_on = 1'b0, force_on = 1'b0;
    logic [63:0] r64;
    logic [7:0] nxt, m_addr;
    logic [1:0] br, m_br;
    logic [2:0] fs, m_fs;
    logic [3:0] sel;
    logic [15:0] m_main;
    logic [17:0] m_fast;
    logic hold_m = 1'b0, pend_m = 1'b0, m_forked = 1'b0;

    microprogram_next_address_sequencer i_dut (
        .aclk(aclk), .aresetn(aresetn), .phase_t1(phase_t1), .phase_t3(phase_t3),
        .force_restart_address(force_restart_address), .decode_state(decode_state),
        .microword(microword), .fork_addr(fork_addr), .branch_cond(branch_cond),
        .console_branch(console_branch), .instr_word(instr_word),
        .microaddress_register(microaddress_register), .main_instr(main_instr),
        .fast_decode_instr_copy(fast_decode_instr_copy),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );

    rom_status_model i_rom (
        .aclk(aclk), .aresetn(aresetn), .run(run), .rom_address(microaddress_register),
        .microword(microword), .phase_t1(phase_t1), .phase_t3(phase_t3)
    );

    always #5 aclk = ~aclk;

    always @(posedge aclk) begin
        r64 = {$random(seed), $random(seed)};
        branch_cond <= r64[35:0];
        fork_addr <= r64[59:36];
        r64 = {$random(seed), $random(seed)};
        instr_word <= r64[15:0];
        console_branch <= r64[23:16];
        decode_state <= r64[24];
        force_restart_address <= force_on & (r64[27:25] == 3'd0);
    end

    // Model of the next-address selection; it reads the values sampled at this edge.
    always @(posedge aclk) begin
        sel = microword.branch_select_field;
        case (sel)
            4'h0, 4'hc: br = 2'b00;
            4'h5: br = {branch_cond.odd_byte_destination, branch_cond.divide_terminate};
            4'hd: br = {branch_cond.flow_jump_class, branch_cond.no_write_class};
            default: br = {branch_cond.cond_hi[sel], branch_cond.cond_lo[sel]};
        endcase
        nxt = microword.next_address_field | {2'b00, br, 4'h0};
        if (sel == 4'hc) nxt = nxt | (console_branch & sequencer_pkg::CONSOLE_MASK);
        fs = 3'b001;
        if (microword.decode_fork_enable) begin
            nxt = nxt & fork_addr.decode_fork_addr;
            fs = 3'b100;
        end else if (microword.operand_fork_enable) begin
            fs = 3'b010;
            if (!(sel == 4'hc && m_main[11:9] inside {3'd3, 3'd5, 3'd7})) begin
                nxt = nxt & fork_addr.operand_fork_addr;
                fs = 3'b100;
            end
        end else if (microword.execute_fork_enable) begin
            fs = 3'b010;
            if (!((sel == 4'hd && !branch_cond.flow_jump_class) ||
                  (sel == 4'h5 && branch_cond.odd_byte_destination))) begin
                nxt = nxt & fork_addr.execute_fork_addr;
                fs = 3'b100;
            end
        end
        if (!aresetn) begin
            m_addr = sequencer_pkg::RESTART_ADDRESS;
            m_main = 16'h0;
            m_fast = 18'h0;
            hold_m = 1'b0;
            pend_m = 1'b0;
            m_br = 2'b00;
            m_fs = 3'b001;
            m_forked = 1'b0;
        end else begin
            if (force_restart_address || (phase_t3 && pend_m)) begin
                m_addr = sequencer_pkg::RESTART_ADDRESS;
                m_forked = 1'b0;
            end else if (phase_t3 && !hold_m) begin
                m_addr = nxt;
                m_forked = (fs != 3'b001);
            end
            // Status capture follows every T3, even a held or restarted one.
            if (phase_t3) begin
                pend_m = 1'b0;
                m_br = br;
                m_fs = fs;
            end
            if (phase_t1 && decode_state && microword.instr_reg_load_bit) begin
                m_main = instr_word;
                m_fast = {instr_word[10], instr_word[9], instr_word};
            end
        end
    end

    task automatic cmp_state(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_ir(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(negedge aclk) begin
        if (cmp_on && m_forked) begin
            cmp_state(microaddress_register, m_addr);
        end else if (cmp_on) begin
            cmp_state(microaddress_register, m_addr);
        end
        if (cmp_on) cmp_ir({main_instr, fast_decode_instr_copy}, {m_main, m_fast});
    end

    task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw_done;
        logic w_done;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic run_cycles(input int n);
        run <= 1'b1;
        repeat (n) @(posedge aclk);
        run <= 1'b0;
    endtask

    task automatic results;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        results();
    end

    initial begin
        for (int i = 0; i < 256; i++) begin
            r64[31:0] = $random(seed);
            w = r64[15:0];
            w.decode_fork_enable = (r64[17:16] == 2'd1);
            w.operand_fork_enable = (r64[17:16] == 2'd2);
            w.execute_fork_enable = (r64[17:16] == 2'd3);
            i_rom.rom[i] = w;
        end
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        cmp_on = 1'b1;
        axi_read(sequencer_pkg::REG_CONTROL, d, r);
        cmp_bus({r, d}, {sequencer_pkg::RESP_OKAY, 32'h0});
        axi_read(12'h010, d, r);
        cmp_bus({r, d}, {sequencer_pkg::RESP_SLVERR, 32'h0});
        axi_write(sequencer_pkg::REG_STATUS, 32'hffffffff, r);
        cmp_bus({r, 32'h0}, {sequencer_pkg::RESP_SLVERR, 32'h0});
        run_cycles(4000);
        axi_read(sequencer_pkg::REG_STATUS, d, r);
        cmp_bus({r, d}, {sequencer_pkg::RESP_OKAY, 19'h0, m_fs, m_br, m_addr});
        axi_read(sequencer_pkg::REG_INSTR, d, r);
        cmp_bus({r, d}, {sequencer_pkg::RESP_OKAY, m_fast[17:16], 14'h0, m_main});
        // Hold freezes normal loads while a restart request still lands at the next T3.
        axi_write(sequencer_pkg::REG_CONTROL, 32'h2, r);
        hold_m = 1'b1;
        axi_read(sequencer_pkg::REG_CONTROL, d, r);
        cmp_bus({r, d}, {sequencer_pkg::RESP_OKAY, 32'h2});
        run_cycles(100);
        axi_write(sequencer_pkg::REG_CONTROL, 32'h3, r);
        pend_m = 1'b1;
        run_cycles(40);
        @(negedge aclk);
        cmp_state(microaddress_register, sequencer_pkg::RESTART_ADDRESS);
        axi_write(sequencer_pkg::REG_CONTROL, 32'h0, r);
        hold_m = 1'b0;
        force_on = 1'b1;
        run_cycles(1000);
        force_on = 1'b0;
        repeat (3) @(posedge aclk);
        results();
    end
endmodule // test_microprogram_next_address_sequencer
